// *** fsc_pkg.sv ***
// fsc_pkg: shared constants and types for the fieldbus slave command frames
package fsc_pkg;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BYTES = 32;
  localparam int IDX_W = 5;
  localparam logic [IDX_W-1:0] LAST_IDX = 5'h1f;
  localparam int B_CODE = 0;
  localparam int B_WDT = 1;
  localparam int B_STAT_LO = 2;
  localparam int B_STAT_HI = 3;
  localparam int B_ARG0 = 4;
  localparam int B_ARG1 = 5;
  localparam int B_ARG2 = 6;
  localparam int B_ARG3 = 7;
  localparam int B_ID0 = 8;
  localparam int ID_BYTES = 8;
  localparam int ID_WORD_BYTES = 4;
  localparam int RSP_KEEP = 16;

  // ---------------------------------------------------------------
  // command codes and identity selectors
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_IDLE = 8'h00;
  localparam logic [7:0] CMD_ID_READ = 8'h03;
  localparam logic [7:0] CMD_SETUP = 8'h04;
  localparam logic [7:0] CMD_ALARM_READ = 8'h05;
  localparam logic [7:0] CMD_ALARM_CLEAR = 8'h06;
  localparam logic [7:0] CMD_CONNECT = 8'h0e;
  localparam logic [7:0] CMD_LINK_CLOSE = 8'h0f;
  localparam logic [7:0] CMD_IO_EXCHANGE = 8'h20;
  localparam logic [7:0] SEL_VENDOR = 8'h01;
  localparam logic [7:0] SEL_DEVICE = 8'h02;
  localparam int CONNECT_SYNC_BIT = 0;

  // ---------------------------------------------------------------
  // status field and alarm codes
  // ---------------------------------------------------------------
  localparam int ST_DEV_ALM = 0;
  localparam int ST_DEV_WARN = 1;
  localparam int ST_CMD_RDY = 2;
  localparam int ST_CALM_LSB = 8;
  localparam int ST_LALM_LSB = 12;
  localparam logic [3:0] ALM_NONE = 4'h0;
  localparam logic [3:0] CALM_UNSUPPORTED = 4'h1;
  localparam logic [3:0] CALM_PHASE = 4'h2;
  localparam logic [3:0] CALM_ID_INVALID = 4'h9;
  localparam logic [3:0] LALM_WDT = 4'h1;
  localparam logic [3:0] LALM_ADDR = 4'h2;
  localparam logic [7:0] STATION_MIN = 8'h03;
  localparam logic [7:0] STATION_MAX = 8'hef;

  // ---------------------------------------------------------------
  // master register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RSP_HDR = 8'h0c;
  localparam logic [7:0] REG_RSP_D0 = 8'h10;
  localparam logic [7:0] REG_RSP_D1 = 8'h14;
  localparam logic [7:0] REG_RSP_D2 = 8'h18;
  localparam int CTRL_GO_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  typedef enum logic [2:0] {
    PH_POWER_ON, PH_WAIT, PH_ASYNC, PH_SYNC, PH_HALT
  } fsc_phase_t;

endpackage : fsc_pkg

// *** fsc_link_if.sv ***
// fsc_link_if: byte-wide frame link between master and slave ends
`timescale 1ns/1ps
interface fsc_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic cmd_valid;
  logic cmd_sof;
  logic [7:0] cmd_byte;
  logic rsp_valid;
  logic rsp_sof;
  logic [7:0] rsp_byte;

  modport master (
    input pclk, presetn, rsp_valid, rsp_sof, rsp_byte,
    output cmd_valid, cmd_sof, cmd_byte
  );
  modport slave (
    input pclk, presetn, cmd_valid, cmd_sof, cmd_byte,
    output rsp_valid, rsp_sof, rsp_byte
  );
endinterface : fsc_link_if

// *** fsc_slave.sv ***
// fsc_slave: slave end that decodes command frames and builds responses
`timescale 1ns/1ps
module fsc_slave #(
  parameter logic [31:0] VENDOR_ID = 32'h0000_00a5, // arbitrary value
  parameter logic [31:0] DEVICE_ID = 32'h0000_5a5a  // arbitrary value
) (
  fsc_link_if.slave link,
  input wire logic [7:0] station_addr,
  input wire logic peer_powered,
  input wire logic dev_alarm,
  input wire logic dev_warn,
  input wire logic [31:0] io_in,
  output fsc_pkg::fsc_phase_t phase,
  output logic [3:0] cmd_alarm,
  output logic [3:0] link_alarm,
  output logic setup_pulse,
  output logic [31:0] setup_data,
  output logic io_pulse,
  output logic [31:0] io_out,
  output logic alarm_clear_pulse
);
  import fsc_pkg::*;

  typedef enum logic [1:0] {S_RX, S_EXEC, S_TX} fsc_sstate_t;

  fsc_sstate_t state_reg;
  fsc_phase_t phase_reg;
  logic [7:0] rx_mem [FRAME_BYTES];
  logic [7:0] tx_mem [FRAME_BYTES];
  logic [IDX_W-1:0] rx_idx_reg;
  logic [IDX_W-1:0] tx_idx_reg;
  logic [IDX_W-1:0] rx_at;
  logic [3:0] calm_reg, calm_next;
  logic [3:0] lalm_reg, lalm_next;
  logic [7:0] wdt_last_reg;
  logic addr_ok_reg;
  logic known, allowed, run, id_ok;
  logic [7:0] code;
  logic [7:0] id_off;
  logic [15:0] id_size;
  logic [31:0] id_word;
  logic [15:0] status;
  fsc_phase_t phase_next;

  // ---------------------------------------------------------------
  // frame reception
  // ---------------------------------------------------------------
  assign rx_at = link.cmd_sof ? '0 : rx_idx_reg;

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      rx_idx_reg <= '0;
    end else if (state_reg == S_RX && link.cmd_valid) begin
      rx_mem[rx_at] <= link.cmd_byte;
      rx_idx_reg <= rx_at + 5'h01;
    end
  end

  // one frame in, one frame out
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      state_reg <= S_RX;
      tx_idx_reg <= '0;
    end else begin
      unique case (state_reg)
        S_RX: begin
          if (link.cmd_valid && rx_at == LAST_IDX) begin
            state_reg <= S_EXEC;
          end
        end
        S_EXEC: begin
          state_reg <= S_TX;
          tx_idx_reg <= '0;
        end
        S_TX: begin
          tx_idx_reg <= tx_idx_reg + 5'h01;
          if (tx_idx_reg == LAST_IDX) begin
            state_reg <= S_RX;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // decode and legality
  // ---------------------------------------------------------------
  assign code = rx_mem[B_CODE];
  assign id_off = rx_mem[B_ARG1];
  assign id_size = {rx_mem[B_ARG3], rx_mem[B_ARG2]};
  assign id_word = (rx_mem[B_ARG0] == SEL_VENDOR) ? VENDOR_ID : DEVICE_ID;

  // command classification and alarm updates
  always_comb begin
    known = 1'b0;
    allowed = 1'b0;
    calm_next = calm_reg;
    lalm_next = lalm_reg;
    phase_next = phase_reg;
    unique case (code)
      CMD_IDLE, CMD_ID_READ, CMD_SETUP, CMD_ALARM_READ,
      CMD_ALARM_CLEAR, CMD_CONNECT, CMD_LINK_CLOSE, CMD_IO_EXCHANGE: known = 1'b1;
      default: known = 1'b0;
    endcase
    unique case (phase_reg)
      // wait and halt phases take idle and connect only, power-on takes none
      PH_WAIT, PH_HALT: allowed = (code == CMD_IDLE) || (code == CMD_CONNECT);
      PH_ASYNC: allowed = known && (code != CMD_IO_EXCHANGE) && (code != CMD_CONNECT);
      PH_SYNC: allowed = known && (code != CMD_CONNECT);
      default: allowed = 1'b0;
    endcase
    id_ok = (rx_mem[B_ARG0] == SEL_VENDOR || rx_mem[B_ARG0] == SEL_DEVICE)
      && id_off < 8'(ID_WORD_BYTES) && id_size != 16'h0000
      && id_size <= 16'(ID_WORD_BYTES) - 16'(id_off);
    run = known && allowed;
    // clear first so a fresh error in this frame still lands
    if (run && code == CMD_ALARM_CLEAR) begin
      calm_next = ALM_NONE;
      lalm_next = ALM_NONE;
    end
    // watchdog must step by one while connected
    if ((phase_reg == PH_ASYNC || phase_reg == PH_SYNC)
        && rx_mem[B_WDT] != wdt_last_reg + 8'h01) begin
      lalm_next = LALM_WDT;
    end
    // unsupported or out-of-phase commands are not run
    if (!known) begin
      calm_next = CALM_UNSUPPORTED;
    end else if (!allowed) begin
      calm_next = CALM_PHASE;
    end else if (code == CMD_ID_READ && !id_ok) begin
      calm_next = CALM_ID_INVALID;
    end
    // connect only with a valid station address
    if (run && code == CMD_CONNECT) begin
      if (!addr_ok_reg) begin
        lalm_next = LALM_ADDR;
      end else if (rx_mem[B_ARG0][CONNECT_SYNC_BIT]) begin
        phase_next = PH_SYNC;
      end else begin
        phase_next = PH_ASYNC;
      end
    end
    if (run && code == CMD_LINK_CLOSE) begin
      phase_next = PH_HALT;
    end
  end

  // ---------------------------------------------------------------
  // phase, alarms and strap capture
  // ---------------------------------------------------------------
  // power-on phase, then waiting once the peer is up
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      phase_reg <= PH_POWER_ON;
    end else if (phase_reg == PH_POWER_ON) begin
      if (peer_powered) begin
        phase_reg <= PH_WAIT;
      end
    end else if (state_reg == S_EXEC) begin
      phase_reg <= phase_next;
    end
  end

  // sticky alarm codes and watchdog history
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      calm_reg <= ALM_NONE;
      lalm_reg <= ALM_NONE;
      wdt_last_reg <= 8'h00;
    end else if (state_reg == S_EXEC) begin
      calm_reg <= calm_next;
      lalm_reg <= lalm_next;
      wdt_last_reg <= rx_mem[B_WDT];
    end
  end

  // station address checked every cycle after release
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      addr_ok_reg <= 1'b0;
    end else begin
      addr_ok_reg <= station_addr >= STATION_MIN && station_addr <= STATION_MAX;
    end
  end

  // ---------------------------------------------------------------
  // response build
  // ---------------------------------------------------------------
  assign status = {lalm_next, calm_next, 5'h00, 1'b1, dev_warn, dev_alarm};

  // zeroed payload unless the command fills it
  always_ff @(posedge link.pclk) begin
    if (state_reg == S_EXEC) begin
      for (int i = 0; i < FRAME_BYTES; i++) begin
        tx_mem[i] <= 8'h00;
      end
      tx_mem[B_CODE] <= code;
      tx_mem[B_WDT] <= rx_mem[B_WDT];
      tx_mem[B_STAT_LO] <= status[7:0];
      tx_mem[B_STAT_HI] <= status[15:8];
      if (run && code == CMD_ID_READ) begin
        // echo arguments, data in bytes 8 to 15
        for (int k = B_ARG0; k < B_ID0; k++) begin
          tx_mem[k] <= rx_mem[k];
        end
        for (int k = 0; k < ID_BYTES; k++) begin
          if (id_ok && 16'(k) < id_size) begin
            tx_mem[B_ID0 + k] <= id_word[8'(31 - 8 * (int'(id_off) + k)) -: 8];
          end
        end
      end
      if (run && code == CMD_ALARM_READ) begin
        tx_mem[B_ARG0] <= {4'h0, calm_reg};
        tx_mem[B_ARG1] <= {4'h0, lalm_reg};
        tx_mem[B_ARG2] <= {6'h00, dev_warn, dev_alarm};
      end
      if (run && code == CMD_IO_EXCHANGE) begin
        {tx_mem[B_ARG3], tx_mem[B_ARG2], tx_mem[B_ARG1], tx_mem[B_ARG0]} <= io_in;
      end
    end
  end

  // response stream, one byte a cycle
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      link.rsp_valid <= 1'b0;
      link.rsp_sof <= 1'b0;
      link.rsp_byte <= 8'h00;
    end else begin
      link.rsp_valid <= state_reg == S_TX;
      link.rsp_sof <= state_reg == S_TX && tx_idx_reg == '0;
      link.rsp_byte <= (state_reg == S_TX) ? tx_mem[tx_idx_reg] : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // user-side strobes
  // ---------------------------------------------------------------
  // one-cycle strobes for executed setup, io exchange and alarm clear commands
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      setup_pulse <= 1'b0;
      io_pulse <= 1'b0;
      alarm_clear_pulse <= 1'b0;
      setup_data <= 32'h0000_0000;
      io_out <= 32'h0000_0000;
    end else begin
      setup_pulse <= state_reg == S_EXEC && run && code == CMD_SETUP;
      io_pulse <= state_reg == S_EXEC && run && code == CMD_IO_EXCHANGE;
      alarm_clear_pulse <= state_reg == S_EXEC && run && code == CMD_ALARM_CLEAR;
      if (state_reg == S_EXEC && run && code == CMD_SETUP) begin
        setup_data <= {rx_mem[B_ARG3], rx_mem[B_ARG2], rx_mem[B_ARG1], rx_mem[B_ARG0]};
      end
      if (state_reg == S_EXEC && run && code == CMD_IO_EXCHANGE) begin
        io_out <= {rx_mem[B_ARG3], rx_mem[B_ARG2], rx_mem[B_ARG1], rx_mem[B_ARG0]};
      end
    end
  end

  assign phase = phase_reg;
  assign cmd_alarm = calm_reg;
  assign link_alarm = lalm_reg;

endmodule : fsc_slave

// *** fsc_master.sv ***
// fsc_master: master end, APB-controlled frame sender and response catcher
`timescale 1ns/1ps
module fsc_master (
  fsc_link_if.master link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import fsc_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_TX, M_RX} fsc_mstate_t;

  fsc_mstate_t state_reg;
  logic [7:0] code_reg;
  logic [31:0] arg_reg;
  logic [7:0] wdt_reg;
  logic done_reg;
  logic [IDX_W-1:0] idx_reg;
  logic [7:0] rsp_mem [RSP_KEEP];
  logic [7:0] tx_byte;
  logic wr_take, go, done_set;
  logic [31:0] rd_word;
  logic rd_hit;

  assign wr_take = psel && penable && pready && pwrite;
  assign go = wr_take && paddr == REG_CTRL && pwdata[CTRL_GO_BIT] && state_reg == M_IDLE;
  assign done_set = state_reg == M_RX && link.rsp_valid && idx_reg == LAST_IDX;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // read data and ready prepared in the setup cycle
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      REG_CTRL: rd_word = {24'h000000, code_reg};
      REG_ARG: rd_word = arg_reg;
      REG_STAT: rd_word = {30'h0, done_reg, state_reg != M_IDLE};
      REG_RSP_HDR: rd_word = {rsp_mem[3], rsp_mem[2], rsp_mem[1], rsp_mem[0]};
      REG_RSP_D0: rd_word = {rsp_mem[7], rsp_mem[6], rsp_mem[5], rsp_mem[4]};
      REG_RSP_D1: rd_word = {rsp_mem[11], rsp_mem[10], rsp_mem[9], rsp_mem[8]};
      REG_RSP_D2: rd_word = {rsp_mem[15], rsp_mem[14], rsp_mem[13], rsp_mem[12]};
      default: rd_hit = 1'b0;
    endcase
  end

  // one wait-free access cycle per transfer
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !rd_hit;
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // command registers, writes ignored while a frame is in flight
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      code_reg <= CMD_IDLE;
      arg_reg <= 32'h0000_0000;
    end else if (wr_take && state_reg == M_IDLE) begin
      if (paddr == REG_CTRL) begin
        code_reg <= pwdata[7:0];
      end
      if (paddr == REG_ARG) begin
        arg_reg <= pwdata;
      end
    end
  end

  // done flag: frame end sets, write-one clears, set wins
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      done_reg <= 1'b0;
    end else if (done_set) begin
      done_reg <= 1'b1;
    end else if (wr_take && paddr == REG_STAT && pwdata[STAT_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // frame exchange
  // ---------------------------------------------------------------
  always_comb begin
    unique case (int'(idx_reg))
      B_CODE: tx_byte = code_reg;
      B_WDT: tx_byte = wdt_reg;
      B_ARG0: tx_byte = arg_reg[7:0];
      B_ARG1: tx_byte = arg_reg[15:8];
      B_ARG2: tx_byte = arg_reg[23:16];
      B_ARG3: tx_byte = arg_reg[31:24];
      default: tx_byte = 8'h00;
    endcase
  end

  // send one frame, then collect its response
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      state_reg <= M_IDLE;
      idx_reg <= '0;
      wdt_reg <= 8'h00;
      link.cmd_valid <= 1'b0;
      link.cmd_sof <= 1'b0;
      link.cmd_byte <= 8'h00;
    end else begin
      link.cmd_valid <= state_reg == M_TX;
      link.cmd_sof <= state_reg == M_TX && idx_reg == '0;
      link.cmd_byte <= (state_reg == M_TX) ? tx_byte : 8'h00;
      unique case (state_reg)
        M_IDLE: begin
          idx_reg <= '0;
          if (go) begin
            state_reg <= M_TX;
          end
        end
        M_TX: begin
          idx_reg <= idx_reg + 5'h01;
          if (idx_reg == LAST_IDX) begin
            state_reg <= M_RX;
            wdt_reg <= wdt_reg + 8'h01;
          end
        end
        M_RX: begin
          if (link.rsp_valid) begin
            idx_reg <= link.rsp_sof ? 5'h01 : idx_reg + 5'h01;
          end
          if (done_set) begin
            state_reg <= M_IDLE;
          end
        end
      endcase
    end
  end

  // keep the first response bytes for software
  always_ff @(posedge link.pclk) begin
    if (state_reg == M_RX && link.rsp_valid && int'(idx_reg) < RSP_KEEP) begin
      rsp_mem[idx_reg[3:0]] <= link.rsp_byte;
    end
  end

endmodule : fsc_master

// *** fsc_link_sva.sv ***
// fsc_link_sva: frame timing and content checks on the master-slave link
`timescale 1ns/1ps
module fsc_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire logic cmd_sof,
  input wire logic [7:0] cmd_byte,
  input wire logic rsp_valid,
  input wire logic rsp_sof,
  input wire logic [7:0] rsp_byte
);
  import fsc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // byte position trackers
  // ----------------------------------------
  logic [4:0] cnt_c;
  logic [4:0] cnt_r;
  logic [7:0] code_reg;
  logic [7:0] wdt_reg;
  wire [4:0] ci = cmd_sof ? 5'h00 : cnt_c;
  wire [4:0] ri = rsp_sof ? 5'h00 : cnt_r;
  // command position and captured header bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_c <= 5'h00;
      code_reg <= 8'h00;
      wdt_reg <= 8'h00;
    end else if (cmd_valid) begin
      cnt_c <= ci + 5'h01;
      if (ci == 5'h00) code_reg <= cmd_byte;
      if (ci == 5'h01) wdt_reg <= cmd_byte;
    end
  end
  // response position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 5'h00;
    end else if (rsp_valid) begin
      cnt_r <= ri + 5'h01;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence cmd_end;
    cmd_valid && ci == LAST_IDX;
  endsequence
  sequence rsp_begin;
    rsp_valid && rsp_sof;
  endsequence
  sof_valid_a: assert property (rsp_sof |-> rsp_valid)
    else $error("response start without valid");
  rsp_run_a: assert property (rsp_valid && !rsp_sof |-> $past(rsp_valid) && $past(ri) != LAST_IDX)
    else $error("response bytes not consecutive");
  rsp_len_a: assert property ($fell(rsp_valid) |-> $past(ri) == LAST_IDX)
    else $error("response frame not 32 bytes");
  cmd_run_a: assert property (cmd_valid && !cmd_sof |-> $past(cmd_valid))
    else $error("command bytes not consecutive");
  rsp_after_a: assert property (cmd_end |=> !rsp_valid ##1 !rsp_valid ##[1:2] rsp_begin)
    else $error("response not started after command");
  one_frame_a: assert property (rsp_valid |-> !cmd_valid)
    else $error("command sent during response");
  idle_echo_a: assert property (rsp_begin and code_reg == CMD_IDLE |-> rsp_byte == CMD_IDLE)
    else $error("idle code not echoed");
  idle_zero_a: assert property (rsp_valid && ri >= 5'h04 && code_reg == CMD_IDLE |-> rsp_byte == 8'h00)
    else $error("idle payload not zero");
  wdt_echo_a: assert property (rsp_valid && ri == 5'h01 |-> rsp_byte == wdt_reg)
    else $error("watchdog count not echoed");
  ready_flag_a: assert property (rsp_valid && ri == 5'h02 |-> rsp_byte[ST_CMD_RDY])
    else $error("command ready flag low");
endmodule : fsc_link_sva

// *** tb.sv ***
// tb: bench joining master and slave ends over the frame link
`timescale 1ns/1ps
module tb;
  import fsc_pkg::*;
  localparam logic [31:0] VEN = 32'h1357_9bdf; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, station_addr;
  logic [31:0] pwdata, prdata, io_in, setup_data, io_out;
  logic peer_powered, dev_alarm, dev_warn, setup_pulse, io_pulse, alarm_clear_pulse;
  logic [3:0] cmd_alarm, link_alarm;
  fsc_phase_t phase;
  logic [31:0] hdr, d0, d1, d2, q;
  logic e;
  int failures = 0;
  int check_count = 0;
  int n_set = 0;
  int n_io = 0;
  int n_clr = 0;
  fsc_link_if link (.pclk(pclk), .presetn(presetn));
  fsc_slave #(.VENDOR_ID(VEN)) i_fsc_slave (.link(link), .station_addr(station_addr),
    .peer_powered(peer_powered), .dev_alarm(dev_alarm), .dev_warn(dev_warn), .io_in(io_in),
    .phase(phase), .cmd_alarm(cmd_alarm), .link_alarm(link_alarm), .setup_pulse(setup_pulse),
    .setup_data(setup_data), .io_pulse(io_pulse), .io_out(io_out),
    .alarm_clear_pulse(alarm_clear_pulse));
  fsc_master i_fsc_master (.link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  fsc_link_sva i_fsc_link_sva (.pclk(pclk), .presetn(presetn), .cmd_valid(link.cmd_valid),
    .cmd_sof(link.cmd_sof), .cmd_byte(link.cmd_byte), .rsp_valid(link.rsp_valid),
    .rsp_sof(link.rsp_sof), .rsp_byte(link.rsp_byte));
  // clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // pulse counters
  always @(posedge pclk) begin
    if (setup_pulse === 1'b1) n_set++;
    if (io_pulse === 1'b1) n_io++;
    if (alarm_clear_pulse === 1'b1) n_clr++;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] a, input logic [31:0] x, input string m);
    check_count++;
    if (a !== x) begin
      failures++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) begin
      cmp(0, 1, "apb hang");
      give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic frame(input logic [7:0] c, input logic [31:0] arg);
    int n;
    n = 0;
    apb(1'b1, REG_ARG, arg);
    apb(1'b1, REG_CTRL, {23'h0, 1'b1, c});
    q = 32'h0;
    while (q[STAT_DONE_BIT] !== 1'b1 && n < 300) begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end
    if (n == 300) begin
      cmp(0, 1, "frame hang");
      give_verdict();
    end
    apb(1'b0, REG_RSP_HDR, 32'h0);
    hdr = q;
    apb(1'b0, REG_RSP_D0, 32'h0);
    d0 = q;
    apb(1'b0, REG_RSP_D1, 32'h0);
    d1 = q;
    apb(1'b0, REG_RSP_D2, 32'h0);
    d2 = q;
    apb(1'b1, REG_STAT, 32'h2);
  endtask : frame
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_wait;
    cmp(32'(phase), 32'(PH_POWER_ON), "not power-on phase");
    peer_powered <= 1'b1;
    repeat (2) @(posedge pclk);
    cmp(32'(phase), 32'(PH_WAIT), "not wait phase");
    frame(CMD_IDLE, 32'hffff_ffff);
    cmp({hdr[18], hdr[7:0]}, 9'h100, "idle header");
    cmp(d0 | d1 | d2, 32'h0, "idle payload");
    frame(CMD_ID_READ, 32'h0004_0001);
    cmp(cmd_alarm, CALM_PHASE, "id read in wait");
    station_addr <= 8'h02;
    frame(CMD_CONNECT, 32'h0);
    cmp({link_alarm, 1'b0, phase}, {LALM_ADDR, 1'b0, PH_WAIT}, "bad station");
    station_addr <= 8'h42;
    frame(CMD_CONNECT, 32'h0);
    cmp(32'(phase), 32'(PH_ASYNC), "not async");
  endtask : t_wait
  task automatic t_async;
    frame(CMD_ALARM_READ, 32'h0);
    cmp(d0[15:0], {4'h0, LALM_ADDR, 4'h0, CALM_PHASE}, "alarm read");
    frame(CMD_ALARM_CLEAR, 32'h0);
    cmp(32'(n_clr), 32'd1, "alarm clear pulse");
    cmp({24'h0, cmd_alarm, link_alarm}, 32'h0, "alarm clear");
    frame(8'h7c, 32'h0);
    cmp(cmd_alarm, CALM_UNSUPPORTED, "unknown code");
    frame(CMD_ALARM_CLEAR, 32'h0);
    frame(CMD_IO_EXCHANGE, 32'h0);
    cmp({cmd_alarm, 28'(n_io)}, {CALM_PHASE, 28'd0}, "sync cmd in async");
    frame(CMD_ALARM_CLEAR, 32'h0);
    frame(CMD_SETUP, 32'hc0de_1234);
    cmp(setup_data, 32'hc0de_1234, "setup data");
    cmp(n_set, 1, "setup pulse");
    frame(CMD_ID_READ, 32'h0004_0001);
    cmp(d0, 32'h0004_0001, "id echo");
    cmp(d1, {<<8{VEN}}, "id data");
    frame(CMD_ID_READ, 32'h0004_0401);
    cmp(cmd_alarm, CALM_ID_INVALID, "bad id read");
    frame(CMD_ALARM_CLEAR, 32'h0);
  endtask : t_async
  task automatic t_sync;
    frame(CMD_LINK_CLOSE, 32'h0);
    cmp(32'(phase), 32'(PH_HALT), "not halted");
    frame(CMD_ID_READ, 32'h0004_0001);
    cmp(cmd_alarm, CALM_PHASE, "id read in halt");
    frame(CMD_CONNECT, 32'h1);
    cmp(32'(phase), 32'(PH_SYNC), "not sync");
    frame(CMD_ALARM_CLEAR, 32'h0);
    io_in <= 32'h5a0f_3c21;
    frame(CMD_IO_EXCHANGE, 32'h8421_0fed);
    cmp({io_out, d0}, {32'h8421_0fed, 32'h5a0f_3c21}, "io exchange");
    cmp(n_io, 1, "io pulse");
    dev_alarm <= 1'b1;
    frame(CMD_IDLE, 32'h0);
    cmp(hdr[16], 1'b1, "device alarm flag");
    apb(1'b0, 8'h40, 32'h0);
    cmp({31'h0, e}, 32'h1, "unmapped read error");
    cmp(q, 32'h0, "unmapped read data");
  endtask : t_sync
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    station_addr = 8'h42;
    peer_powered = 1'b0;
    dev_alarm = 1'b0;
    dev_warn = 1'b0;
    io_in = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_wait();
    t_async();
    t_sync();
    give_verdict();
  end
endmodule : tb
